/* rtl/fldrv_pkg.sv */
// Package for the flash driver register bank and its controller.
// Assumes both ends, the link assertions and the bench import it.
package fldrv_pkg;
   // ************************************************************
   // Device side: link address and register map
   // ************************************************************
   localparam logic [6:0] FLD_CHIP_ADDR = 7'h63;
   localparam logic [7:0] FLD_ENABLE_OFS = 8'h01;
   localparam logic [7:0] FLD_MONITOR_OFS = 8'h02;
   localparam logic [7:0] FLD_FL1_OFS = 8'h03;
   localparam logic [7:0] FLD_FL2_OFS = 8'h04;
   localparam logic [7:0] FLD_TO1_OFS = 8'h05;
   localparam logic [7:0] FLD_TO2_OFS = 8'h06;
   localparam logic [7:0] FLD_LAST_CFG_OFS = 8'h09;
   localparam logic [7:0] FLD_FLAGS1_OFS = 8'h0A;
   localparam logic [7:0] FLD_FLAGS2_OFS = 8'h0B;
   localparam logic [7:0] FLD_PART_ID_OFS = 8'h0C;
   localparam logic [7:0] FLD_LAST_FLASH_OFS = 8'h0D;
   // Reset values of the writable registers 0x01..0x09
   localparam logic [7:0] FLD_RESET [1:9] = '{8'h80, 8'h01, 8'hBF, 8'h3F, 8'hBF, 8'h3F, 8'h09, 8'h1A, 8'h08};
   localparam logic [7:0] FLD_FLAGS_RESET = 8'h00;
   // Enable register fields
   localparam int FLD_EN_RFSYNC_BIT = 7;
   localparam int FLD_EN_TRIG_EDGE_BIT = 6;
   localparam int FLD_EN_TRIG_EN_BIT = 5;
   localparam int FLD_EN_TORCH_PIN_BIT = 4;
   localparam int FLD_EN_MODE_LSB = 2;
   localparam int FLD_EN_SECOND_BIT = 1;
   localparam int FLD_EN_FIRST_BIT = 0;
   // Monitor register fields
   localparam int FLD_IV_LOCKOUT_BIT = 6;
   localparam int FLD_IV_LEVEL_LSB = 3;
   localparam int FLD_IV_HYST_BIT = 2;
   localparam int FLD_FOLLOW_BIT = 7;
   localparam int FLD_LOCKOUT_FLAG_BIT = 1;
   localparam logic [11:0] FLD_IV_BASE_MV = 12'hB54;
   localparam logic [11:0] FLD_IV_STEP_MV = 12'h064;
   // Operating modes
   typedef enum logic [1:0] {
      FLD_STANDBY = 2'b00,
      FLD_INFRARED = 2'b01,
      FLD_TORCH = 2'b10,
      FLD_FLASH = 2'b11
   } fldrv_mode_t;
   // ************************************************************
   // Controller side: APB map and timing
   // ************************************************************
   localparam logic [7:0] FLC_CMD_OFS = 8'h00;
   localparam logic [7:0] FLC_STATUS_OFS = 8'h04;
   localparam logic [7:0] FLC_IRQ_STATUS_OFS = 8'h08;
   localparam logic [7:0] FLC_IRQ_CLEAR_OFS = 8'h0C;
   localparam logic [7:0] FLC_IRQ_ENABLE_OFS = 8'h10;
   localparam int FLC_CMD_READ_BIT = 16;
   localparam logic [3:0] FLC_ACK_WAIT_CYCLES = 4'h8;
   localparam int FLC_IRQ_DONE_BIT = 0;
   localparam int FLC_IRQ_NACK_BIT = 1;
   typedef enum logic [1:0] {
      FLC_IDLE = 2'b00,
      FLC_SEND = 2'b01,
      FLC_WAIT = 2'b10
   } fldrv_host_state_t;
endpackage : fldrv_pkg

/* rtl/fldrv_link_if.sv */
// Byte link between the controller and the flash driver register bank.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface fldrv_link_if;
   logic byte_valid;
   logic first;
   logic [7:0] byte_data;
   logic ack;
   logic rd_valid;
   logic [7:0] rd_data;
   modport dev (input byte_valid, input first, input byte_data, output ack, output rd_valid, output rd_data);
   modport host (output byte_valid, output first, output byte_data, input ack, input rd_valid, input rd_data);
endinterface : fldrv_link_if
`default_nettype wire

/* rtl/fldrv_device.sv */
// Register bank of the dual-emitter flash driver, reached over the byte link.
// Assumes fault events arrive as one-cycle pulses synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - enable register 0x01, reset 0x80, field layout
// - no edge trigger in infrared mode
// - software keeps trigger type while enabled
// - trigger pulses last longer than 1ms
// - monitor register resets 0x01, field layout
// - threshold code maps 2.9V plus 0.1V steps
// - monitor mode frozen unless in standby
// - first flash level 0x03, reset 0xBF, follow bit
// - second flash level 0x04, reset 0x3F
// - first torch level 0x05, reset 0xBF, follow bit
// - second torch level 0x06, reset 0x3F
// - reading first flag register clears, releases lockout
// - write frame: address, register, then data
module fldrv_device
   import fldrv_pkg::*;
#(
   parameter logic [7:0] PART_ID = 8'hA5 // Arbitrary identification value
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Link to controller
   fldrv_link_if.dev link,
   // Status from the analog side
   input wire logic [7:0] flag1_events,
   input wire logic [7:0] flag2_state,
   input wire logic [7:0] last_flash_code,
   // Mode and trigger controls
   output logic [1:0] op_mode,
   output logic rf_sync_pin_en,
   output logic trigger_edge,
   output logic trigger_en,
   output logic torch_pin_en,
   output logic first_emitter_on,
   output logic second_emitter_on,
   output logic undervoltage_lockout_en,
   output logic undervoltage_lockout_hold,
   // Input voltage monitor
   output logic [11:0] monitor_threshold_mv,
   output logic monitor_hyst_50mv,
   output logic [1:0] monitor_behaviour,
   // Current codes
   output logic [6:0] first_flash_code,
   output logic [6:0] second_flash_code,
   output logic [6:0] first_torch_code,
   output logic [6:0] second_torch_code
);
   // ************************************************************
   // Storage and link state
   // ************************************************************
   typedef enum logic [1:0] {
      FLD_ST_ADDR = 2'b00,
      FLD_ST_REG = 2'b01,
      FLD_ST_DATA = 2'b10,
      FLD_ST_IGNORE = 2'b11
   } fldrv_dev_state_t;
   fldrv_dev_state_t state_reg;
   logic [7:0] cfg_reg [1:9];
   logic [7:0] ptr_reg;
   logic [7:0] flags1_reg;
   logic flags1_read;
   logic cfg_write;
   logic [7:0] en_v;
   logic [7:0] iv_v;
   logic [1:0] mode_v;

   // Read decode for the read answer; the clear-on-read decodes the pointer itself
   function automatic logic [7:0] fldrv_read_byte(input logic [7:0] a);
      logic [7:0] d;
      d = 8'h00;
      if (a >= FLD_ENABLE_OFS && a <= FLD_LAST_CFG_OFS) begin
         d = cfg_reg[a[3:0]];
      end else if (a == FLD_FLAGS1_OFS) begin
         d = flags1_reg;
      end else if (a == FLD_FLAGS2_OFS) begin
         d = flag2_state;
      end else if (a == FLD_PART_ID_OFS) begin
         d = PART_ID;
      end else if (a == FLD_LAST_FLASH_OFS) begin
         d = last_flash_code;
      end
      return d;
   endfunction : fldrv_read_byte

   // Frame decode terms
   assign flags1_read = link.byte_valid && link.first && link.byte_data[7:1] == FLD_CHIP_ADDR
                        && link.byte_data[0] && ptr_reg == FLD_FLAGS1_OFS;
   assign cfg_write = link.byte_valid && !link.first && state_reg == FLD_ST_DATA
                      && ptr_reg >= FLD_ENABLE_OFS && ptr_reg <= FLD_LAST_CFG_OFS;
   assign en_v = cfg_reg[1];
   assign iv_v = cfg_reg[2];
   assign mode_v = undervoltage_lockout_hold ? FLD_STANDBY : en_v[FLD_EN_MODE_LSB +: 2];

   // ************************************************************
   // Link framing
   // ************************************************************
   // A first byte always restarts the frame, so a lost byte never wedges the link
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= FLD_ST_ADDR;
         ptr_reg <= 8'h00;
         link.ack <= 1'b0;
         link.rd_valid <= 1'b0;
         link.rd_data <= 8'h00;
      end else begin
         link.ack <= 1'b0;
         link.rd_valid <= 1'b0;
         if (link.byte_valid) begin
            if (link.first) begin
               if (link.byte_data[7:1] != FLD_CHIP_ADDR) begin
                  state_reg <= FLD_ST_IGNORE;
               end else if (link.byte_data[0]) begin
                  // Read frame answers at once with the selected register
                  link.ack <= 1'b1;
                  link.rd_valid <= 1'b1;
                  link.rd_data <= fldrv_read_byte(ptr_reg);
                  state_reg <= FLD_ST_IGNORE;
               end else begin
                  link.ack <= 1'b1;
                  state_reg <= FLD_ST_REG;
               end
            end else if (state_reg == FLD_ST_REG) begin
               ptr_reg <= link.byte_data;
               link.ack <= 1'b1;
               state_reg <= FLD_ST_DATA;
            end else if (state_reg == FLD_ST_DATA) begin
               link.ack <= 1'b1;
               state_reg <= FLD_ST_IGNORE;
            end
         end
      end
   end

   // ************************************************************
   // Writable registers
   // ************************************************************
   // Monitor mode bits cannot change while the driver is active
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 1; i <= 9; i++) begin
            cfg_reg[i] <= FLD_RESET[i];
         end
      end else if (cfg_write) begin
         if (ptr_reg == FLD_MONITOR_OFS && en_v[FLD_EN_MODE_LSB +: 2] != FLD_STANDBY) begin
            cfg_reg[2] <= {link.byte_data[7:2], iv_v[1:0]};
         end else if (ptr_reg == FLD_FL2_OFS || ptr_reg == FLD_TO2_OFS) begin
            cfg_reg[ptr_reg[3:0]] <= {1'b0, link.byte_data[6:0]};
         end else begin
            cfg_reg[ptr_reg[3:0]] <= link.byte_data;
         end
      end
   end

   // ************************************************************
   // Fault flags and lockout
   // ************************************************************
   // A new event in the clearing cycle survives the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flags1_reg <= FLD_FLAGS_RESET;
         undervoltage_lockout_hold <= 1'b0;
      end else begin
         flags1_reg <= (flags1_read ? 8'h00 : flags1_reg) | flag1_events;
         if (flag1_events[FLD_LOCKOUT_FLAG_BIT]) begin
            undervoltage_lockout_hold <= 1'b1;
         end else if (flags1_read) begin
            undervoltage_lockout_hold <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Analog controls
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_mode <= FLD_STANDBY;
         rf_sync_pin_en <= 1'b0;
         trigger_edge <= 1'b0;
         trigger_en <= 1'b0;
         torch_pin_en <= 1'b0;
         first_emitter_on <= 1'b0;
         second_emitter_on <= 1'b0;
         undervoltage_lockout_en <= 1'b0;
         monitor_threshold_mv <= FLD_IV_BASE_MV;
         monitor_hyst_50mv <= 1'b0;
         monitor_behaviour <= 2'b00;
      end else begin
         op_mode <= mode_v;
         rf_sync_pin_en <= en_v[FLD_EN_RFSYNC_BIT];
         // Edge triggering is masked in infrared mode
         trigger_edge <= en_v[FLD_EN_TRIG_EDGE_BIT] && mode_v != FLD_INFRARED;
         trigger_en <= en_v[FLD_EN_TRIG_EN_BIT];
         torch_pin_en <= en_v[FLD_EN_TORCH_PIN_BIT];
         first_emitter_on <= en_v[FLD_EN_FIRST_BIT] && mode_v != FLD_STANDBY;
         second_emitter_on <= en_v[FLD_EN_SECOND_BIT] && mode_v != FLD_STANDBY;
         undervoltage_lockout_en <= iv_v[FLD_IV_LOCKOUT_BIT];
         monitor_threshold_mv <= FLD_IV_BASE_MV + 12'(iv_v[FLD_IV_LEVEL_LSB +: 3]) * FLD_IV_STEP_MV;
         monitor_hyst_50mv <= iv_v[FLD_IV_HYST_BIT];
         monitor_behaviour <= iv_v[1:0];
      end
   end

   // Current codes, zero unless the emitter is on in torch or flash
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         first_flash_code <= 7'h00;
         second_flash_code <= 7'h00;
         first_torch_code <= 7'h00;
         second_torch_code <= 7'h00;
      end else begin
         first_flash_code <= (mode_v == FLD_FLASH && en_v[FLD_EN_FIRST_BIT]) ? cfg_reg[3][6:0] : 7'h00;
         second_flash_code <= (mode_v == FLD_FLASH && en_v[FLD_EN_SECOND_BIT])
                              ? (cfg_reg[3][FLD_FOLLOW_BIT] ? cfg_reg[3][6:0] : cfg_reg[4][6:0]) : 7'h00;
         first_torch_code <= (mode_v == FLD_TORCH && en_v[FLD_EN_FIRST_BIT]) ? cfg_reg[5][6:0] : 7'h00;
         second_torch_code <= (mode_v == FLD_TORCH && en_v[FLD_EN_SECOND_BIT])
                              ? (cfg_reg[5][FLD_FOLLOW_BIT] ? cfg_reg[5][6:0] : cfg_reg[6][6:0]) : 7'h00;
      end
   end
endmodule : fldrv_device
`default_nettype wire

/* rtl/fldrv_host.sv */
// Link controller for the flash driver, ordered by software over APB.
// Assumes the device answers each byte within a few cycles or not at all.
`timescale 1ns/1ps
`default_nettype none
module fldrv_host
   import fldrv_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Interrupt
   output logic irq,
   // Link to device
   fldrv_link_if.host link
);
   // ************************************************************
   // State
   // ************************************************************
   fldrv_host_state_t state_reg;
   logic [1:0] step_reg;
   logic [3:0] wait_reg;
   logic is_read_reg;
   logic [7:0] reg_sel_reg;
   logic [7:0] data_reg;
   logic [7:0] rdata_reg;
   logic [1:0] irq_status_reg;
   logic [1:0] irq_enable_reg;
   logic setup;
   logic wr_cmd;
   logic wr_clear;
   logic done_ev;
   logic nack_ev;

   assign setup = psel && !penable;
   assign wr_cmd = setup && pwrite && paddr == FLC_CMD_OFS && state_reg == FLC_IDLE;
   assign wr_clear = setup && pwrite && paddr == FLC_IRQ_CLEAR_OFS;
   assign done_ev = state_reg == FLC_WAIT && (link.ack || link.rd_valid) && step_reg == 2'd2;
   assign nack_ev = state_reg == FLC_WAIT && !link.ack && wait_reg == 4'h0;

   // ************************************************************
   // APB slave: answers in the cycle after setup
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         irq_enable_reg <= 2'b00;
      end else begin
         pready <= setup;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         if (setup) begin
            if (paddr == FLC_CMD_OFS) begin
               prdata <= {15'h0000, is_read_reg, data_reg, reg_sel_reg};
            end else if (paddr == FLC_STATUS_OFS) begin
               prdata <= {16'h0000, rdata_reg, 7'h00, state_reg != FLC_IDLE};
            end else if (paddr == FLC_IRQ_STATUS_OFS) begin
               prdata <= {30'h0000_0000, irq_status_reg};
            end else if (paddr == FLC_IRQ_ENABLE_OFS) begin
               prdata <= {30'h0000_0000, irq_enable_reg};
               if (pwrite) begin
                  irq_enable_reg <= pwdata[1:0];
               end
            end else if (paddr != FLC_IRQ_CLEAR_OFS) begin
               pslverr <= 1'b1;
            end
         end
      end
   end

   // Sticky events; an event in the clearing cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status_reg <= 2'b00;
         irq <= 1'b0;
      end else begin
         irq_status_reg <= (irq_status_reg & ~(wr_clear ? pwdata[1:0] : 2'b00)) | {nack_ev, done_ev};
         irq <= |(irq_status_reg & irq_enable_reg);
      end
   end

   // ************************************************************
   // Byte sequencer
   // ************************************************************
   // Read is a pointer write frame, then a read frame
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= FLC_IDLE;
         step_reg <= 2'd0;
         wait_reg <= 4'h0;
         is_read_reg <= 1'b0;
         reg_sel_reg <= 8'h00;
         data_reg <= 8'h00;
         rdata_reg <= 8'h00;
         link.byte_valid <= 1'b0;
         link.first <= 1'b0;
         link.byte_data <= 8'h00;
      end else begin
         link.byte_valid <= 1'b0;
         case (state_reg)
            FLC_IDLE: begin
               if (wr_cmd) begin
                  reg_sel_reg <= pwdata[7:0];
                  data_reg <= pwdata[15:8];
                  is_read_reg <= pwdata[FLC_CMD_READ_BIT];
                  step_reg <= 2'd0;
                  state_reg <= FLC_SEND;
               end
            end
            FLC_SEND: begin
               link.byte_valid <= 1'b1;
               link.first <= step_reg == 2'd0 || (step_reg == 2'd2 && is_read_reg);
               if (step_reg == 2'd0) begin
                  link.byte_data <= {FLD_CHIP_ADDR, 1'b0};
               end else if (step_reg == 2'd1) begin
                  link.byte_data <= reg_sel_reg;
               end else begin
                  link.byte_data <= is_read_reg ? {FLD_CHIP_ADDR, 1'b1} : data_reg;
               end
               wait_reg <= FLC_ACK_WAIT_CYCLES;
               state_reg <= FLC_WAIT;
            end
            FLC_WAIT: begin
               if (link.ack) begin
                  if (link.rd_valid) begin
                     rdata_reg <= link.rd_data;
                  end
                  step_reg <= step_reg + 2'd1;
                  state_reg <= (step_reg == 2'd2) ? FLC_IDLE : FLC_SEND;
               end else if (wait_reg == 4'h0) begin
                  state_reg <= FLC_IDLE;
               end else begin
                  wait_reg <= wait_reg - 4'h1;
               end
            end
            default: begin
               state_reg <= FLC_IDLE;
            end
         endcase
      end
   end
endmodule : fldrv_host
`default_nettype wire

/* sim/fldrv_link_assertions.sv */
// Concurrent checks on the byte link between controller and register bank.
// Assumes the plain signals of one link instance and a single clock.
`timescale 1ns/1ps
`default_nettype none
module fldrv_link_assertions
   import fldrv_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Link signals
   input wire logic byte_valid,
   input wire logic first,
   input wire logic [7:0] byte_data,
   input wire logic ack,
   input wire logic rd_valid,
   input wire logic [7:0] rd_data
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   // ************************************************************
   // Link handshake
   // ************************************************************
   // Address byte carrying our own chip address
   logic own_addr;
   assign own_addr = byte_valid && first && (byte_data[7:1] == FLD_CHIP_ADDR);
   addr_acked_a: assert property (own_addr |=> ack)
      else $error("address byte not acknowledged");
   read_answer_a: assert property (own_addr && byte_data[0] |=> rd_valid && ack)
      else $error("read address gave no read data");
   write_no_read_a: assert property (own_addr && !byte_data[0] |=> !rd_valid)
      else $error("read data on a write frame");
   ack_has_cause_a: assert property (ack |-> $past(byte_valid))
      else $error("ack without a byte");
   rdata_held_a: assert property (!rd_valid |-> $stable(rd_data))
      else $error("read data moved without read strobe");
   ack_pulse_a: assert property (ack |=> !ack)
      else $error("ack longer than one cycle");
   byte_spacing_a: assert property (byte_valid |=> !byte_valid ##1 !byte_valid)
      else $error("bytes closer than the handshake allows");
   body_acked_a: assert property (byte_valid && !first |=> ack)
      else $error("frame body byte not acknowledged");
   // Main traffic kinds
   cover property (own_addr && byte_data[0]);
   cover property (own_addr && !byte_data[0]);
   cover property (rd_valid);
endmodule : fldrv_link_assertions
`default_nettype wire

/* sim/flash_led_driver_regs_tb.sv */
// Bench for controller and register bank joined by the byte link.
// Assumes the package constants; software is played over APB tasks.
`timescale 1ns/1ps
`default_nettype none
module flash_led_driver_regs_tb import fldrv_pkg::*;;
   // ************************************************************
   // Signals and instances
   // ************************************************************
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, flag1_events = 8'h00, flag2_state = 8'h5A, last_flash_code = 8'h3C, b;
   logic [31:0] pwdata = 32'h0, prdata, d;
   logic pready, pslverr, irq, e, rf_sync_pin_en, trigger_edge, trigger_en, torch_pin_en;
   logic first_emitter_on, second_emitter_on, undervoltage_lockout_en, undervoltage_lockout_hold, monitor_hyst_50mv;
   logic [1:0] op_mode, monitor_behaviour, md;
   logic [11:0] monitor_threshold_mv;
   logic [6:0] first_flash_code, second_flash_code, first_torch_code, second_torch_code;
   int n_errors = 0, num_checks = 0;
   always #10 pclk = ~pclk;
   fldrv_link_if lnk ();
   fldrv_host u_fldrv_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .link(lnk));
   fldrv_device u_fldrv_device (.pclk(pclk), .presetn(presetn), .link(lnk), .flag1_events(flag1_events),
      .flag2_state(flag2_state), .last_flash_code(last_flash_code), .op_mode(op_mode),
      .rf_sync_pin_en(rf_sync_pin_en), .trigger_edge(trigger_edge), .trigger_en(trigger_en),
      .torch_pin_en(torch_pin_en), .first_emitter_on(first_emitter_on), .second_emitter_on(second_emitter_on),
      .undervoltage_lockout_en(undervoltage_lockout_en), .undervoltage_lockout_hold(undervoltage_lockout_hold),
      .monitor_threshold_mv(monitor_threshold_mv), .monitor_hyst_50mv(monitor_hyst_50mv),
      .monitor_behaviour(monitor_behaviour),
      .first_flash_code(first_flash_code), .second_flash_code(second_flash_code),
      .first_torch_code(first_torch_code), .second_torch_code(second_torch_code));
   fldrv_link_assertions u_fldrv_link_assertions (.pclk(pclk), .presetn(presetn), .byte_valid(lnk.byte_valid),
      .first(lnk.first), .byte_data(lnk.byte_data), .ack(lnk.ack), .rd_valid(lnk.rd_valid), .rd_data(lnk.rd_data));
   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // One APB transfer; an idle edge first so psel never toggles twice at once
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Busy poll; a hang is cut by the watchdog
   task automatic wait_idle();
      do apb(1'b0, FLC_STATUS_OFS, 32'h0); while (d[0] !== 1'b0);
   endtask : wait_idle
   task automatic dev_wr(input logic [7:0] r, input logic [7:0] v);
      apb(1'b1, FLC_CMD_OFS, {16'h0000, v, r});
      wait_idle();
   endtask : dev_wr
   task automatic dev_rd(input logic [7:0] r);
      apb(1'b1, FLC_CMD_OFS, {15'h0000, 1'b1, 8'h00, r});
      wait_idle();
      b = d[15:8];
   endtask : dev_rd
   task automatic give_verdict();
      if (n_errors == 0 && num_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : give_verdict
   // Watchdog sized well above the planned traffic
   initial begin
      repeat (40000) @(posedge pclk);
      n_errors++;
      give_verdict();
   end
   // ************************************************************
   // Tests
   // ************************************************************
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      // Outputs leave reset at the next edge; look once they have settled
      @(posedge pclk);
      @(negedge pclk);
      chk({rf_sync_pin_en, monitor_behaviour, op_mode}, 5'h14);
      chk(monitor_threshold_mv, 12'hB54);
      chk(first_flash_code, 7'h00);
      apb(1'b1, FLC_IRQ_ENABLE_OFS, 32'h1);
      chk(irq, 1'b0);
      for (int r = 1; r < 10; r++) begin
         dev_rd(r[7:0]);
         chk(b, FLD_RESET[r]);
      end
      apb(1'b0, FLC_IRQ_STATUS_OFS, 32'h0);
      chk(d, 32'h1);
      chk(irq, 1'b1);
      apb(1'b1, FLC_IRQ_CLEAR_OFS, 32'h1);
      apb(1'b1, FLC_IRQ_ENABLE_OFS, 32'h0);
      dev_rd(FLD_PART_ID_OFS);
      chk(b, 8'hA5);
      chk(irq, 1'b0);
      apb(1'b0, 8'h14, 32'h0);
      chk(e, 1'b1);
      chk(d, 32'h0);
      // Every mode with both emitters, edge strobe requested
      for (int m = 0; m < 4; m++) begin
         md = m[1:0];
         dev_wr(FLD_ENABLE_OFS, {4'b0110, md, 2'b11});
         chk(op_mode, md);
         chk(trigger_edge, md != 2'b01);
         chk({rf_sync_pin_en, trigger_en, torch_pin_en}, 3'b010);
         chk({first_emitter_on, second_emitter_on}, (md != 2'b00) ? 2'b11 : 2'b00);
         chk({first_flash_code, second_flash_code}, (md == 2'b11) ? 14'h1FBF : 14'h0);
         chk({first_torch_code, second_torch_code}, (md == 2'b10) ? 14'h1FBF : 14'h0);
      end
      // Monitor mode frozen while active, free in standby
      dev_wr(FLD_MONITOR_OFS, 8'h7C);
      dev_rd(FLD_MONITOR_OFS);
      chk(b, 8'h7D);
      chk({undervoltage_lockout_en, monitor_hyst_50mv, monitor_behaviour}, 4'hD);
      chk(monitor_threshold_mv, 12'hE10);
      // Back in standby the monitor mode bits change freely
      dev_wr(FLD_ENABLE_OFS, 8'h00);
      dev_wr(FLD_MONITOR_OFS, 8'h1B);
      dev_rd(FLD_MONITOR_OFS);
      chk(b, 8'h1B);
      chk({undervoltage_lockout_en, monitor_hyst_50mv, monitor_behaviour}, 4'h3);
      chk(monitor_threshold_mv, FLD_IV_BASE_MV + 12'h003 * FLD_IV_STEP_MV);
      // Follow bits off for flash, on for torch
      dev_wr(FLD_FL1_OFS, 8'h10);
      dev_wr(FLD_FL2_OFS, 8'hFF);
      dev_wr(FLD_TO1_OFS, 8'h85);
      dev_wr(FLD_TO2_OFS, 8'hC4);
      dev_rd(FLD_FL2_OFS);
      chk(b, 8'h7F);
      dev_rd(FLD_TO2_OFS);
      chk(b, 8'h44);
      // Command word keeps the last read order
      apb(1'b0, FLC_CMD_OFS, 32'h0);
      chk(d, 32'h0001_0006);
      dev_wr(FLD_ENABLE_OFS, 8'h0F);
      chk({first_flash_code, second_flash_code}, {7'h10, 7'h7F});
      chk({first_torch_code, second_torch_code}, 14'h0);
      dev_wr(FLD_ENABLE_OFS, 8'h0B);
      chk({first_torch_code, second_torch_code}, {7'h05, 7'h05});
      chk({first_flash_code, second_flash_code}, 14'h0);
      dev_wr(FLD_ENABLE_OFS, 8'h0D);
      chk({first_flash_code, second_flash_code, second_emitter_on}, {7'h10, 7'h00, 1'b0});
      // Strobe pins stay undriven here, so pulse width is the pin owner's duty
      // Undervoltage event latches until the first flag register is read
      @(posedge pclk);
      flag1_events <= 8'h02;
      @(posedge pclk);
      flag1_events <= 8'h00;
      repeat (2) @(posedge pclk);
      chk({undervoltage_lockout_hold, op_mode}, 3'b100);
      dev_rd(FLD_FLAGS1_OFS);
      chk(b, 8'h02);
      chk({undervoltage_lockout_hold, op_mode}, 3'b011);
      dev_rd(FLD_FLAGS1_OFS);
      chk(b, FLD_FLAGS_RESET);
      // Live status places and an unmapped place
      dev_rd(FLD_FLAGS2_OFS);
      chk(b, 8'h5A);
      dev_rd(FLD_LAST_FLASH_OFS);
      chk(b, 8'h3C);
      dev_rd(8'h0E);
      chk(b, 8'h00);
      apb(1'b0, FLC_IRQ_STATUS_OFS, 32'h0);
      chk(d, 32'h1);
      chk(irq, 1'b0);
      give_verdict();
   end
endmodule : flash_led_driver_regs_tb
`default_nettype wire
